// ===== dv/fsl_host.sv
// host side of the reset pin
`timescale 1ns/1ps
module fsl_host (
   input  wire drive_en,
   input  wire drive_lvl,
   output wire pin_lvl
);
   // undriven line shows a low level; the pull-up is inside the block
   assign pin_lvl = drive_en ? drive_lvl : 1'b0;
endmodule

// ===== dv/fsl_top_monitor.sv
// checker for the status latch and reset control
`timescale 1ns/1ps
module fsl_top_monitor (
   input wire clock, rst, reset_pin_n, reset_pin_oe, reset_strobe, fault_parity, fault_overtemp,
   input wire fault_clock, fault_terminal, self_test_input, self_test_polarity_bit, normal_mode,
   input wire status_out, status_oe, self_test_active, deflect_pos, deflect_neg,
   input wire spi_enable, internal_reset, status_latch
);
   wire flt = fault_parity | fault_overtemp | fault_clock;
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   a_hiz_hold: assert property ($fell(rst) |-> !status_oe [*8]) else $error("status driven early");
   a_hiz_end: assert property ($fell(rst) |-> ##[9:13] status_oe) else $error("status not driven");
   a_stab_keep: assert property ($rose(status_oe) |-> (status_out && status_latch) [*8])
      else $error("status cleared in delay");
   a_clear_cause: assert property ($fell(status_latch) |-> $past(self_test_input, 4))
      else $error("clear without edge");
   a_fault_set: assert property (flt |=> status_latch) else $error("fault not latched");
   a_out_latch: assert property (status_oe && $past(status_oe) |-> status_out == status_latch)
      else $error("status pin differs from latch");
   a_terminal_hold: assert property (fault_terminal |=> ##1 status_latch [*8]) else $error("terminal cleared");
   a_rst_pulse: assert property (internal_reset |=> !internal_reset) else $error("reset pulse long");
   a_rst_cause: assert property (internal_reset |-> $past(reset_strobe, 4) && $past(reset_pin_oe, 4)
      && !$past(reset_pin_n, 4)) else $error("reset without pins");
   a_spi_mode: assert property (!$past(rst) |-> spi_enable == !$past(normal_mode))
      else $error("serial enable wrong");
   a_test_on: assert property (self_test_input [*5] |-> self_test_active) else $error("self-test off");
   a_defl_pol: assert property (deflect_pos |-> !self_test_polarity_bit) else $error("wrong deflection");
   cover property ($fell(status_latch));
   cover property (internal_reset);
   cover property (deflect_neg);
endmodule
bind fsl_top fsl_top_monitor mon (.*);

// ===== dv/fsl_top_tb.sv
// testbench for the status latch and reset control
`timescale 1ns/1ps
module fsl_top_tb;
   logic clock = 0, rst = 1, reset_pin_oe = 0, lvl = 1, reset_strobe = 0, fault_parity = 0;
   logic fault_overtemp = 0, fault_clock = 0, fault_terminal = 0, self_test_input = 0;
   logic self_test_polarity_bit = 0, normal_mode = 1;
   wire  reset_pin_n, status_out, status_oe, self_test_active, deflect_pos, deflect_neg;
   wire  spi_enable, internal_reset, status_latch;
   int   n_errors = 0, n_compared = 0, cycles = 0;
   fsl_host h (.drive_en(reset_pin_oe), .drive_lvl(lvl), .pin_lvl(reset_pin_n));
   fsl_top #(.RST_HOLD_CYC(17'h8), .HIZ_CYC(17'hA), .STAB_CYC(17'h14)) dut (.*);
   initial forever #20 clock = ~clock;
   task cyc(input int n); repeat (n) @(posedge clock); #1; endtask
   task chk(input logic a, input logic e);
      n_compared++;
      if (a !== e) begin
         n_errors++;
         $display("[FAIL] %0t got %h exp %h", $time, a, e);
      end
   endtask
   task pulse; @(posedge clock) self_test_input <= 1; cyc(5); @(posedge clock) self_test_input <= 0; cyc(2); endtask
   task close_out;
      $display("compared %0d errors %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   always @(posedge clock) if (++cycles > 3000) begin n_errors++; close_out; end
   task t_boot;
      cyc(5); chk(status_oe, 0);
      cyc(9); chk(status_oe, 1); chk(status_out, 1);
      pulse; chk(status_latch, 1);
      cyc(12); chk(spi_enable, 0);
      @(posedge clock) normal_mode <= 0;
      cyc(2); chk(spi_enable, 1);
      @(posedge clock) normal_mode <= 1;
      cyc(2); chk(spi_enable, 0);
      $display("boot done");
   endtask
   task t_clear;
      pulse; chk(status_latch, 0); chk(status_out, 0);
      for (int i = 0; i < 3; i++) begin
         @(posedge clock) {fault_clock, fault_overtemp, fault_parity} <= 3'h1 << i;
         cyc(2); chk(status_out, 1);
         pulse; chk(status_latch, 1);
         @(posedge clock) {fault_clock, fault_overtemp, fault_parity} <= 3'h0;
         pulse; chk(status_latch, 0);
      end
      $display("clear done");
   endtask
   task t_test;
      for (int p = 0; p < 2; p++) begin
         @(posedge clock) self_test_polarity_bit <= p[0];
         self_test_input <= 1;
         cyc(5); chk(self_test_active, 1);
         chk(deflect_pos, !p[0]); chk(deflect_neg, p[0]);
         @(posedge clock) self_test_input <= 0;
         cyc(5); chk(self_test_active, 0);
      end
      $display("self-test done");
   endtask
   task t_pin;
      int k;
      @(posedge clock) reset_strobe <= 1;
      lvl <= 0;
      cyc(20); chk(status_oe, 1);
      @(posedge clock) reset_pin_oe <= 1;
      k = 0;
      while (!internal_reset && k < 30) begin cyc(1); k++; end
      chk(internal_reset, 1);
      @(posedge clock) reset_pin_oe <= 0;
      cyc(2); chk(status_oe, 0); chk(status_latch, 1);
      cyc(35); $display("pin reset done");
   endtask
   task t_term;
      @(posedge clock) fault_terminal <= 1;
      @(posedge clock) fault_terminal <= 0;
      pulse; pulse; chk(status_latch, 1);
      $display("terminal done");
   endtask
   initial begin
      repeat (3) @(posedge clock);
      rst <= 0;
      t_boot; t_clear; t_test; t_pin; t_term;
      close_out;
   end
endmodule

// ===== pkg/fsl_map.vh
// constants for the fault status latch and reset control block
`ifndef FSL_MAP_VH
`define FSL_MAP_VH

// ==========================================
// clock and times
`define FSL_CLK_HZ        25000000
`define FSL_RST_HOLD_US   512
`define FSL_HIZ_US        800
`define FSL_STAB_MS       3
// interval lengths in clock cycles at the clock above, sized to the counter
`define FSL_RST_HOLD_CYC  17'h03200
`define FSL_HIZ_CYC       17'h04E20
`define FSL_STAB_CYC      17'h124F8

// ==========================================
// counter width
`define FSL_CNT_W         17

// ==========================================
// supervision states
`define FSL_SEQ_RUN       2'h0
`define FSL_SEQ_HIZ       2'h1
`define FSL_SEQ_STAB      2'h2

`endif

// ===== verilog/fsl_top.v
// fault status latch, pin reset qualifier and self-test control
`timescale 1ns/1ps
`include "fsl_map.vh"

module fsl_top #(
   parameter [`FSL_CNT_W-1:0] RST_HOLD_CYC = `FSL_RST_HOLD_CYC,
   parameter [`FSL_CNT_W-1:0] HIZ_CYC      = `FSL_HIZ_CYC,
   parameter [`FSL_CNT_W-1:0] STAB_CYC     = `FSL_STAB_CYC
) (
   // clock and power-on reset
   input  wire clock,
   input  wire rst,
   // reset pin pair
   input  wire reset_pin_n,
   input  wire reset_pin_oe,
   input  wire reset_strobe,
   // fault sources
   input  wire fault_parity,
   input  wire fault_overtemp,
   input  wire fault_clock,
   input  wire fault_terminal,
   // self-test pin and polarity, operating mode
   input  wire self_test_input,
   input  wire self_test_polarity_bit,
   input  wire normal_mode,
   // status pin
   output reg  status_out,
   output reg  status_oe,
   // self-test, mode, reset and status latch outputs
   output reg  self_test_active,
   output reg  deflect_pos,
   output reg  deflect_neg,
   output reg  spi_enable,
   output reg  internal_reset,
   output reg  status_latch
);

   // ==========================================
   // last count of each timed interval
   localparam [`FSL_CNT_W-1:0] RST_HOLD_LAST = RST_HOLD_CYC - 1'b1;
   localparam [`FSL_CNT_W-1:0] HIZ_LAST      = HIZ_CYC - 1'b1;
   localparam [`FSL_CNT_W-1:0] STAB_LAST     = STAB_CYC - 1'b1;

   // ==========================================
   // reset pin qualification
   reg [`FSL_CNT_W-1:0] hold_cnt_reg;
   wire                 rst_pin_eff;
   wire                 rst_pin_sync;
   wire                 strobe_sync;
   wire                 qual_active;
   wire                 qual_hit;
   wire                 dev_reset;

   // pull-up: undriven pin reads high
   assign rst_pin_eff = reset_pin_oe ? reset_pin_n : 1'b1;

   // both pin levels pass two flops before use
   fsl_sync2 #(
      .RST_VAL (1'b1)
   ) rst_pin_sync_u (
      .clock (clock),
      .rst   (rst),
      .din   (rst_pin_eff),
      .dout  (rst_pin_sync)
   );

   fsl_sync2 #(
      .RST_VAL (1'b0)
   ) strobe_sync_u (
      .clock (clock),
      .rst   (rst),
      .din   (reset_strobe),
      .dout  (strobe_sync)
   );

   // pin low with strobe high, as seen after the synchronizers
   assign qual_active = !rst_pin_sync && strobe_sync;
   assign qual_hit    = qual_active && (hold_cnt_reg == RST_HOLD_LAST);
   assign dev_reset   = rst | internal_reset;

   // hold counter; any break in the hold restarts it
   always @(posedge clock) begin
      if (rst) begin
         hold_cnt_reg <= {`FSL_CNT_W{1'b0}};
      end else if (qual_active && !qual_hit) begin
         hold_cnt_reg <= hold_cnt_reg + 1'b1;
      end else begin
         hold_cnt_reg <= {`FSL_CNT_W{1'b0}};
      end
   end

   // one-cycle internal reset pulse; a longer hold gives another
   always @(posedge clock) begin
      if (rst) begin
         internal_reset <= 1'b0;
      end else begin
         internal_reset <= qual_hit;
      end
   end

   // ==========================================
   // self-test synchronizer and edge detect
   wire selftest_sync;
   reg  selftest_prev_reg;
   reg  clear_pulse_reg;

   // pin level crosses into the internal clock here
   fsl_sync2 #(
      .RST_VAL (1'b0)
   ) selftest_sync_u (
      .clock (clock),
      .rst   (rst),
      .din   (self_test_input),
      .dout  (selftest_sync)
   );

   // previous level resets low like the idle pin: no false edge
   always @(posedge clock) begin
      if (rst) begin
         selftest_prev_reg <= 1'b0;
         clear_pulse_reg   <= 1'b0;
      end else begin
         selftest_prev_reg <= selftest_sync;
         clear_pulse_reg   <= selftest_sync & ~selftest_prev_reg;
      end
   end

   // ==========================================
   // self-test stimulus
   // the polarity bit picks one direction: deflect_pos when low, deflect_neg when high
   always @(posedge clock) begin
      if (rst) begin
         self_test_active <= 1'b0;
         deflect_pos      <= 1'b0;
         deflect_neg      <= 1'b0;
      end else begin
         self_test_active <= selftest_sync;
         deflect_pos      <= selftest_sync & ~self_test_polarity_bit;
         deflect_neg      <= selftest_sync & self_test_polarity_bit;
      end
   end

   // ==========================================
   // pin function by operating mode
   always @(posedge clock) begin
      if (rst) begin
         spi_enable <= 1'b0;
      end else begin
         spi_enable <= ~normal_mode;
      end
   end

   // ==========================================
   // fault sources
   reg  term_reg;
   wire fault_live;
   wire fault_now;

   // live faults set the latch while present
   assign fault_live = fault_parity | fault_overtemp | fault_clock;
   // a terminal fault never lets go, so every clear is undone
   assign fault_now  = fault_live | term_reg;

   // terminal fault is sticky until power-on reset
   always @(posedge clock) begin
      if (rst) begin
         term_reg <= 1'b0;
      end else if (fault_terminal) begin
         term_reg <= 1'b1;
      end
   end

   // ==========================================
   // post-reset sequence
   localparam [1:0] SEQ_RUN  = `FSL_SEQ_RUN;
   localparam [1:0] SEQ_HIZ  = `FSL_SEQ_HIZ;
   localparam [1:0] SEQ_STAB = `FSL_SEQ_STAB;

   reg [1:0]            state_reg;
   reg [1:0]            state_next;
   reg [`FSL_CNT_W-1:0] seq_cnt_reg;
   reg [`FSL_CNT_W-1:0] seq_cnt_next;

   // next state and interval count
   always @* begin
      state_next   = state_reg;
      seq_cnt_next = seq_cnt_reg + 1'b1;
      case (state_reg)
         SEQ_HIZ: begin
            // pin floats until this interval runs out
            if (seq_cnt_reg == HIZ_LAST) begin
               state_next   = SEQ_STAB;
               seq_cnt_next = {`FSL_CNT_W{1'b0}};
            end
         end

         SEQ_STAB: begin
            // internal circuitry settling; clears refused here
            if (seq_cnt_reg == STAB_LAST) begin
               state_next   = SEQ_RUN;
               seq_cnt_next = {`FSL_CNT_W{1'b0}};
            end
         end

         SEQ_RUN: begin
            seq_cnt_next = {`FSL_CNT_W{1'b0}};
         end

         default: begin
            state_next   = SEQ_HIZ;
            seq_cnt_next = {`FSL_CNT_W{1'b0}};
         end
      endcase
   end

   // internal reset restarts the sequence just like power-on reset
   always @(posedge clock) begin
      if (dev_reset) begin
         state_reg   <= SEQ_HIZ;
         seq_cnt_reg <= {`FSL_CNT_W{1'b0}};
      end else begin
         state_reg   <= state_next;
         seq_cnt_reg <= seq_cnt_next;
      end
   end

   // ==========================================
   // status latch and status pin
   wire clear_ok;
   wire drive_next;
   wire latch_next;

   // clears only count once the stabilization delay is over
   assign clear_ok   = clear_pulse_reg && (state_reg == SEQ_RUN);
   assign drive_next = (state_next != SEQ_HIZ);
   // set wins over clear; a fault still present re-sets at once
   assign latch_next = fault_now | (status_latch & ~clear_ok);

   // reset and initialization are reported as a set latch
   always @(posedge clock) begin
      if (dev_reset) begin
         status_latch <= 1'b1;
      end else begin
         status_latch <= latch_next;
      end
   end

   // pin mirrors the latch once it is driven
   always @(posedge clock) begin
      if (dev_reset) begin
         status_out <= 1'b0;
         status_oe  <= 1'b0;
      end else begin
         status_out <= drive_next & latch_next;
         status_oe  <= drive_next;
      end
   end

endmodule

// ==========================================
// two-flop synchronizer for one pin level
// reset value matches the pin's idle level
module fsl_sync2 #(
   parameter [0:0] RST_VAL = 1'b0
) (
   // clock and reset
   input  wire clock,
   input  wire rst,
   // pin level in, synchronized level out
   input  wire din,
   output wire dout
);

   reg meta_reg;
   reg sync_reg;

   // only the second flop is read outside
   assign dout = sync_reg;

   always @(posedge clock) begin
      if (rst) begin
         meta_reg <= RST_VAL;
         sync_reg <= RST_VAL;
      end else begin
         meta_reg <= din;
         sync_reg <= meta_reg;
      end
   end

endmodule
